// ---- hw/bridge_pkg.sv ----
// Constants, register map and pixel carriers for the display bridge output formatter.
// Assumes a single 20 MHz system clock; the bench supplies the pixel stream and link clock.
//
// Functional notes
// - Output carries no pixel data until configuration complete.
// - Writing ones clears error flag registers.
// - Single-link and dual-link output supported.
// - Dual-link: odd pixels link A, even B.
// - No stream data: zero pixels, syncs kept.
// - Layout bits select 24-bit layout per link.
// - First layout puts colour LSBs on pair four.
// - Link A narrow mode disables pair four.
// - Single-link narrow: link B, A pair four low.
// - Link arrangement bit selects single or dual.
package bridge_pkg;

    localparam int ADDR_W = 8;

    localparam logic [7:0] OFF_RESET_CTL  = 8'h09;
    localparam logic [7:0] OFF_PLL_CTL    = 8'h0d;
    localparam logic [7:0] OFF_LINK_CFG   = 8'h18;
    localparam logic [7:0] OFF_ERR_FIRST  = 8'he5;
    localparam logic [7:0] OFF_ERR_SECOND = 8'he6;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'hf0;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'hf1;
    localparam logic [7:0] OFF_IRQ_CLEAR  = 8'hf2;

    localparam int BIT_PLL_RUN      = 0;
    localparam int BIT_REINIT       = 0;
    localparam int BIT_B_LAYOUT     = 0;
    localparam int BIT_A_LAYOUT     = 1;
    localparam int BIT_A_WIDE       = 3;
    localparam int BIT_SINGLE_LINK  = 4;

    localparam int IRQ_BITS         = 4;
    localparam int IRQ_ERR_FIRST    = 0;
    localparam int IRQ_ERR_SECOND   = 1;
    localparam int IRQ_FRAME_START  = 2;
    localparam int IRQ_REINIT_DONE  = 3;

    localparam logic [7:0] CFG_RESET   = 8'h00;
    localparam logic [7:0] ERR_CLEARED = 8'h00;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } pixel_t;

    typedef struct packed {
        logic       hsync;
        logic       vsync;
        logic       de;
        pixel_t     pix;
    } video_t;

    // One link of the output: its clock lane plus four data pairs of seven bits each.
    typedef struct packed {
        logic       clk;
        logic [6:0] pair0;
        logic [6:0] pair1;
        logic [6:0] pair2;
        logic [6:0] pair3;
    } lvds_word_t;

    typedef struct packed {
        logic single_link;
        logic a_wide;
        logic a_layout;
        logic b_layout;
    } link_cfg_t;

endpackage

// ---- hw/link_edge_sync.sv ----
// Two-flop synchroniser with a rising-edge pulse for the external link clock.
// Assumes the link clock is much slower than mclk.
`timescale 1ns/1ps
module link_edge_sync (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      level,
    output logic      rise
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;
    logic prev_r;
    logic prev_nxt;

    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~prev_r;
endmodule

// ---- hw/lvds_packer.sv ----
// Packs one pixel with its sync states into the four seven-bit data pairs of a link.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module lvds_packer (
    input  bridge_pkg::video_t     vid,
    input  wire logic              wide,
    input  wire logic              layout_first,
    input  wire logic              link_clk,
    output bridge_pkg::lvds_word_t word
);
    bridge_pkg::pixel_t p;

    always_comb begin
        p = vid.pix;
        word.clk   = link_clk;
        // Pairs 0..2 carry six bits of each colour; which six depends on the layout.
        if (layout_first) begin
            word.pair0 = {p.green[2], p.red[7:2]};
            word.pair1 = {p.blue[3:2], p.green[7:3]};
            word.pair2 = {vid.de, vid.vsync, vid.hsync, p.blue[7:4]};
            word.pair3 = {1'b0, p.blue[1:0], p.green[1:0], p.red[1:0]};
        end else begin
            word.pair0 = {p.green[0], p.red[5:0]};
            word.pair1 = {p.blue[1:0], p.green[5:1]};
            word.pair2 = {vid.de, vid.vsync, vid.hsync, p.blue[5:2]};
            word.pair3 = {1'b0, p.blue[7:6], p.green[7:6], p.red[7:6]};
        end
        if (!wide) begin
            word.pair3 = 7'h00;
        end
    end
endmodule

// ---- hw/bridge_formatter.sv ----
// Output formatter of the display bridge: configuration registers, error flags and link packing.
// Assumes the pixel stream arrives on mclk and the link clock is an unsynchronised input.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module bridge_formatter (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic [7:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    input  bridge_pkg::video_t      vid_in,
    input  wire logic               vid_valid,
    input  wire logic [7:0]         err_first_set,
    input  wire logic [7:0]         err_second_set,
    input  wire logic               link_clk_in,
    output bridge_pkg::lvds_word_t  link_a,
    output bridge_pkg::lvds_word_t  link_b,
    output logic                    pll_run,
    output logic                    irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus. Every access answers one cycle after it is presented.

    logic [7:0]  cfg_r;
    logic [7:0]  cfg_nxt;
    logic [7:0]  pll_r;
    logic [7:0]  pll_nxt;
    logic [7:0]  err1_r;
    logic [7:0]  err1_nxt;
    logic [7:0]  err2_r;
    logic [7:0]  err2_nxt;
    logic [3:0]  ien_r;
    logic [3:0]  ien_nxt;
    logic [3:0]  ist_r;
    logic [3:0]  ist_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        cfg_done_r;
    logic        cfg_done_nxt;
    logic        reinit_r;
    logic        reinit_nxt;
    logic        wr;
    logic        rd;
    logic [7:0]  wbyte;
    logic [3:0]  events;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // A write lands at the edge where waitrequest is low, the one edge the master treats as the transfer.
    assign wr    = avs_write & ack_r & avs_byteenable[0];
    assign rd    = avs_read & ~ack_r;
    assign wbyte = avs_writedata[7:0];
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign avs_readdata    = rdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Link timing and output formatting.

    logic                   lclk_level;
    logic                   lclk_rise;
    logic                   parity_r;
    logic                   parity_nxt;
    logic                   vs_prev_r;
    logic                   vs_prev_nxt;
    bridge_pkg::video_t     held_r;
    bridge_pkg::video_t     held_nxt;
    bridge_pkg::video_t     odd_r;
    bridge_pkg::video_t     odd_nxt;
    bridge_pkg::video_t     pair_a_r;
    bridge_pkg::video_t     pair_a_nxt;
    bridge_pkg::video_t     pair_b_r;
    bridge_pkg::video_t     pair_b_nxt;
    bridge_pkg::video_t     eff;
    bridge_pkg::video_t     vid_a;
    bridge_pkg::video_t     vid_b;
    bridge_pkg::lvds_word_t word_a;
    bridge_pkg::lvds_word_t word_b;
    bridge_pkg::lvds_word_t link_a_r;
    bridge_pkg::lvds_word_t link_a_nxt;
    bridge_pkg::lvds_word_t link_b_r;
    bridge_pkg::lvds_word_t link_b_nxt;
    bridge_pkg::link_cfg_t  lc;
    logic                   active;

    assign lc.single_link = cfg_r[bridge_pkg::BIT_SINGLE_LINK];
    assign lc.a_wide      = cfg_r[bridge_pkg::BIT_A_WIDE];
    assign lc.a_layout    = cfg_r[bridge_pkg::BIT_A_LAYOUT];
    assign lc.b_layout    = cfg_r[bridge_pkg::BIT_B_LAYOUT];

    // Pixels are withheld until the host has configured, started the PLL and re-initialised.
    assign active = cfg_done_r & pll_r[bridge_pkg::BIT_PLL_RUN] & reinit_r;

    always_comb begin
        cfg_nxt      = cfg_r;
        pll_nxt      = pll_r;
        ien_nxt      = ien_r;
        cfg_done_nxt = cfg_done_r;
        reinit_nxt   = reinit_r;
        ack_nxt      = (avs_read | avs_write) & ~ack_r;
        rdata_nxt    = rdata_r;
        err1_nxt     = err1_r;
        err2_nxt     = err2_r;
        if (wr) begin
            if (hit(avs_address, bridge_pkg::OFF_LINK_CFG)) begin
                cfg_nxt      = wbyte;
                cfg_done_nxt = 1'b1;
            end
            if (hit(avs_address, bridge_pkg::OFF_PLL_CTL)) begin
                pll_nxt = wbyte;
            end
            // The re-init bit is self-clearing; it arms the output path if the PLL runs and disarms it if not.
            if (hit(avs_address, bridge_pkg::OFF_RESET_CTL) && wbyte[bridge_pkg::BIT_REINIT]) begin
                reinit_nxt = pll_r[bridge_pkg::BIT_PLL_RUN];
            end
            if (hit(avs_address, bridge_pkg::OFF_IRQ_ENABLE)) begin
                ien_nxt = wbyte[bridge_pkg::IRQ_BITS-1:0];
            end
            if (hit(avs_address, bridge_pkg::OFF_ERR_FIRST)) begin
                err1_nxt = err1_r & ~wbyte;
            end
            if (hit(avs_address, bridge_pkg::OFF_ERR_SECOND)) begin
                err2_nxt = err2_r & ~wbyte;
            end
        end
        // New errors win over a clear in the same cycle.
        err1_nxt = err1_nxt | err_first_set;
        err2_nxt = err2_nxt | err_second_set;
        if (rd) begin
            rdata_nxt = 32'h0000_0000;
            unique case (avs_address)
                bridge_pkg::OFF_LINK_CFG:   rdata_nxt[7:0] = cfg_r;
                bridge_pkg::OFF_PLL_CTL:    rdata_nxt[7:0] = pll_r;
                bridge_pkg::OFF_ERR_FIRST:  rdata_nxt[7:0] = err1_r;
                bridge_pkg::OFF_ERR_SECOND: rdata_nxt[7:0] = err2_r;
                bridge_pkg::OFF_IRQ_STATUS: rdata_nxt[3:0] = ist_r;
                bridge_pkg::OFF_IRQ_ENABLE: rdata_nxt[3:0] = ien_r;
                default:                    rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Frame start only counts while the output is armed, so bring-up traffic raises no frame start.
    always_comb begin
        events = '0;
        events[bridge_pkg::IRQ_ERR_FIRST]   = |err_first_set;
        events[bridge_pkg::IRQ_ERR_SECOND]  = |err_second_set;
        events[bridge_pkg::IRQ_FRAME_START] = vid_in.vsync & ~vs_prev_r & active;
        events[bridge_pkg::IRQ_REINIT_DONE] = reinit_nxt & ~reinit_r;
        ist_nxt = ist_r;
        if (wr && hit(avs_address, bridge_pkg::OFF_IRQ_CLEAR)) begin
            ist_nxt = ist_r & ~wbyte[bridge_pkg::IRQ_BITS-1:0];
        end
        ist_nxt = ist_nxt | events;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_r      <= bridge_pkg::CFG_RESET;
            pll_r      <= bridge_pkg::CFG_RESET;
            err1_r     <= bridge_pkg::ERR_CLEARED;
            err2_r     <= bridge_pkg::ERR_CLEARED;
            ien_r      <= '0;
            ist_r      <= '0;
            ack_r      <= 1'b0;
            rdata_r    <= 32'h0000_0000;
            cfg_done_r <= 1'b0;
            reinit_r   <= 1'b0;
        end else begin
            cfg_r      <= cfg_nxt;
            pll_r      <= pll_nxt;
            err1_r     <= err1_nxt;
            err2_r     <= err2_nxt;
            ien_r      <= ien_nxt;
            ist_r      <= ist_nxt;
            ack_r      <= ack_nxt;
            rdata_r    <= rdata_nxt;
            cfg_done_r <= cfg_done_nxt;
            reinit_r   <= reinit_nxt;
        end
    end

    // The interrupt is a level: it drops only once software clears or masks the status bit.
    assign irq     = |(ist_r & ien_r);
    assign pll_run = pll_r[bridge_pkg::BIT_PLL_RUN];

    ////////////////////////////////////////////////////////////////////////////////
    // Pixel path.

    link_edge_sync u_lclk (
        .mclk     (mclk),
        .rst      (rst),
        .async_in (link_clk_in),
        .level    (lclk_level),
        .rise     (lclk_rise)
    );

    // Without stream data the colour is zero but sync states keep flowing.
    always_comb begin
        eff          = vid_in;
        if (!(vid_valid && vid_in.de && active)) begin
            eff.pix = '0;
            eff.de  = 1'b0;
        end
    end

    always_comb begin
        held_nxt    = held_r;
        odd_nxt     = odd_r;
        pair_a_nxt  = pair_a_r;
        pair_b_nxt  = pair_b_r;
        parity_nxt  = parity_r;
        vs_prev_nxt = vid_in.vsync;
        if (lclk_rise) begin
            held_nxt = eff;
            if (!eff.de) begin
                parity_nxt = 1'b0;
                pair_a_nxt = eff;
                pair_b_nxt = eff;
            end else begin
                parity_nxt = ~parity_r;
                if (!parity_r) begin
                    odd_nxt = eff;
                end else begin
                    pair_a_nxt = odd_r;
                    pair_b_nxt = eff;
                end
            end
        end
    end

    // A dual-link pair is shown only once its even pixel lands, so link B never repeats an odd pixel.
    // Blank periods pass straight through to keep the sync states flowing on both links.
    always_comb begin
        vid_a = held_r;
        vid_b = held_r;
        if (!lc.single_link) begin
            vid_a = pair_a_r;
            vid_b = pair_b_r;
        end
    end

    lvds_packer u_pack_a (
        .vid          (vid_a),
        .wide         (lc.a_wide),
        .layout_first (lc.a_layout),
        .link_clk     (lclk_level),
        .word         (word_a)
    );

    lvds_packer u_pack_b (
        .vid          (vid_b),
        .wide         (lc.a_wide),
        .layout_first (lc.b_layout),
        .link_clk     (lclk_level),
        .word         (word_b)
    );

    always_comb begin
        link_a_nxt = word_a;
        link_b_nxt = word_b;
        if (lc.single_link) begin
            link_b_nxt = '0;
        end
        if (!active) begin
            link_b_nxt.pair0[6:4] = '0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            held_r    <= '0;
            odd_r     <= '0;
            pair_a_r  <= '0;
            pair_b_r  <= '0;
            parity_r  <= 1'b0;
            vs_prev_r <= 1'b0;
            link_a_r  <= '0;
            link_b_r  <= '0;
        end else begin
            held_r    <= held_nxt;
            odd_r     <= odd_nxt;
            pair_a_r  <= pair_a_nxt;
            pair_b_r  <= pair_b_nxt;
            parity_r  <= parity_nxt;
            vs_prev_r <= vs_prev_nxt;
            link_a_r  <= link_a_nxt;
            link_b_r  <= link_b_nxt;
        end
    end

    assign link_a = link_a_r;
    assign link_b = link_b_r;

endmodule

// ---- verification/bridge_formatter_props.sv ----
// Checker for the bridge formatter: bus handshake, error clearing, link output levels.
// Assumes a master that holds each request until it sees waitrequest low.
`timescale 1ns/1ps
module bridge_formatter_props (
    input wire logic             mclk,
    input wire logic             rst,
    input wire logic [7:0]       avs_address,
    input wire logic             avs_read,
    input wire logic             avs_write,
    input wire logic [31:0]      avs_writedata,
    input wire logic [3:0]       avs_byteenable,
    input wire logic [31:0]      avs_readdata,
    input wire logic             avs_waitrequest,
    input bridge_pkg::video_t    vid_in,
    input wire logic             vid_valid,
    input wire logic [7:0]       err_first_set,
    input wire logic [7:0]       err_second_set,
    input wire logic             link_clk_in,
    input bridge_pkg::lvds_word_t link_a,
    input bridge_pkg::lvds_word_t link_b,
    input wire logic             pll_run,
    input wire logic             irq
);
    logic [7:0] cfg_r, cfg_nxt;
    logic       req, acc_w, acc_r;
    assign req   = avs_read | avs_write;
    assign acc_w = avs_write & !avs_waitrequest & avs_byteenable[0];
    assign acc_r = avs_read & !avs_waitrequest;
    // Shadow of the link setup, so the output checks know the mode.
    always_comb begin
        cfg_nxt = cfg_r;
        if (acc_w && avs_address == bridge_pkg::OFF_LINK_CFG) begin
            cfg_nxt = avs_writedata[7:0];
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_r <= 8'h00;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    AST_WAIT_FIRST: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("request taken without a wait cycle");
    AST_WAIT_ONE: assert property (req && avs_waitrequest ##1 req |-> !avs_waitrequest)
        else $error("second wait cycle seen");
    AST_PLL_SET:
        assert property (acc_w && avs_address == bridge_pkg::OFF_PLL_CTL |=> pll_run == $past(avs_writedata[0]))
        else $error("pll_run does not follow its register bit");
    // Link outputs follow a mode change within two mclk of the write, well inside the 16-cycle settling window.
    AST_B_OFF:
        assert property (cfg_r[4] && $past(cfg_r[4], 16) |-> link_b == '0)
        else $error("link b active in single-link mode");
    AST_PAIR3_NARROW:
        assert property (!cfg_r[3] && !$past(cfg_r[3], 16) |-> link_a.pair3 == 7'h00 && link_b.pair3 == 7'h00)
        else $error("fourth pair active in narrow mode");
    AST_ERR_CLEAR:
        assert property (acc_w && avs_address == bridge_pkg::OFF_ERR_FIRST && avs_writedata[7:0] == 8'hff
            && !err_first_set ##1 !err_first_set ##1 (avs_read && avs_address == bridge_pkg::OFF_ERR_FIRST
            && !err_first_set) ##1 (acc_r && !err_first_set) |-> avs_readdata[7:0] == 8'h00)
        else $error("error flags not cleared");
    AST_HIGH_ZERO: assert property (acc_r |-> avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_UNMAPPED: assert property (acc_r && !(avs_address inside {8'h09, 8'h0d, 8'h18, 8'he5, 8'he6,
        8'hf0, 8'hf1, 8'hf2}) |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    cover property (acc_w && avs_address == bridge_pkg::OFF_ERR_FIRST);
    cover property ($rose(link_b.clk));
    cover property (acc_r && avs_address == bridge_pkg::OFF_IRQ_STATUS);
endmodule
bind bridge_formatter bridge_formatter_props u_props (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .vid_in(vid_in), .vid_valid(vid_valid),
    .err_first_set(err_first_set), .err_second_set(err_second_set), .link_clk_in(link_clk_in),
    .link_a(link_a), .link_b(link_b), .pll_run(pll_run), .irq(irq)
);

// ---- verification/lvds_panel_model.sv ----
// Flat-panel stand-in: counts the clock rises it sees on each output link.
// Assumes the link clock is far slower than mclk, so no rise is missed.
`timescale 1ns/1ps
module lvds_panel_model (
    input wire logic              mclk,
    input wire logic              rst,
    input bridge_pkg::lvds_word_t link_a,
    input bridge_pkg::lvds_word_t link_b,
    output logic [15:0]           a_edges,
    output logic [15:0]           b_edges
);
    logic a_q, b_q;
    // A link clock held low makes its count stop, which the bench watches.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            a_edges <= 16'h0000;
            b_edges <= 16'h0000;
        end else begin
            a_q <= link_a.clk;
            b_q <= link_b.clk;
            a_edges <= a_edges + 16'(link_a.clk & !a_q);
            b_edges <= b_edges + 16'(link_b.clk & !b_q);
        end
    end
endmodule

// ---- verification/tb_bridge_formatter.sv ----
// Bench for the bridge formatter: bring-up, link modes, error flags and interrupt.
// Assumes link outputs settle within six mclk of a pixel being driven.
`timescale 1ns/1ps
module tb_bridge_formatter;
    logic                   mclk, rst, avs_read, avs_write, avs_waitrequest, vid_valid, link_clk_in, pll_run, irq;
    logic [7:0]             avs_address, err_first_set, err_second_set, pz, v;
    logic [31:0]            avs_writedata, avs_readdata;
    logic [3:0]             avs_byteenable;
    bridge_pkg::video_t     vid_in;
    bridge_pkg::lvds_word_t link_a, link_b;
    logic [15:0]            a_edges, b_edges, b_mark;
    logic [7:0]             exp_q[$];
    int                     fail_count, n_compared, k;

    bridge_formatter dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .vid_in(vid_in), .vid_valid(vid_valid),
        .err_first_set(err_first_set), .err_second_set(err_second_set), .link_clk_in(link_clk_in),
        .link_a(link_a), .link_b(link_b), .pll_run(pll_run), .irq(irq));
    lvds_panel_model panel (.mclk(mclk), .rst(rst), .link_a(link_a), .link_b(link_b), .a_edges(a_edges),
        .b_edges(b_edges));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Offset start keeps link edges clear of mclk edges.
    initial begin
        link_clk_in = 1'b0;
        #130;
        forever #200 link_clk_in = ~link_clk_in;
    end
    ////////////////////////////////////////
    task automatic stop_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [31:0] pairs(input bridge_pkg::lvds_word_t w);
        return {4'h0, w.pair0, w.pair1, w.pair2, w.pair3};
    endfunction
    // Waitrequest is read right at each rising edge, before that edge's register updates land.
    task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge mclk);
        avs_read <= rd;
        avs_write <= !rd;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b0, a, d, 4'hf);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 8'h00, 4'hf);
    endtask
    task automatic px(input logic de, input logic [23:0] c);
        @(posedge link_clk_in);
        @(posedge mclk);
        // Blank pixels raise both syncs, so the blank checks see them kept.
        vid_in <= {~de, ~de, de, c};
        vid_valid <= de;
        repeat (6) @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        if (avs_read && !avs_waitrequest) begin
            check("readdata", {24'h0, exp_q.pop_front()}, avs_readdata);
        end
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        stop_test();
    end
    ////////////////////////////////////////
    initial begin
        k = $urandom(32'h5a33);
        {rst, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = {2'b10, 45'h0};
        {vid_in, vid_valid, err_first_set, err_second_set} = '0;
        fail_count = 0;
        n_compared = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        check("irq", 32'h0, {31'h0, irq});
        rd(bridge_pkg::OFF_LINK_CFG, bridge_pkg::CFG_RESET);
        rd(8'h40, 8'h00);
        px(1'b1, 24'($urandom));
        check("link_a before setup", 32'h0, pairs(link_a));
        wr(bridge_pkg::OFF_LINK_CFG, 8'h12);
        wr(bridge_pkg::OFF_PLL_CTL, 8'h01);
        rd(bridge_pkg::OFF_PLL_CTL, 8'h01);
        check("pll_run", 32'h1, {31'h0, pll_run});
        wr(bridge_pkg::OFF_RESET_CTL, 8'h01);
        rd(bridge_pkg::OFF_LINK_CFG, 8'h12);
        b_mark = b_edges;
        for (k = 0; k < 4; k++) begin
            px(1'b1, 24'($urandom));
            check("link_b", 32'h0, {3'h0, link_b});
            check("link_a pair3", 32'h0, {25'h0, link_a.pair3});
        end
        px(1'b0, 24'($urandom));
        check("link_a blank", 32'h0000_1800, pairs(link_a));
        check("link_b clock", {16'h0, b_mark}, {16'h0, b_edges});
        for (k = 0; k < 2; k++) begin
            pz = (k == 1) ? 8'hfc : 8'h3f;
            wr(bridge_pkg::OFF_LINK_CFG, 8'h18 | 8'(k << 1));
            px(1'b1, {3{pz}});
            check("pair3 unused bits", 32'h0, {25'h0, link_a.pair3});
            px(1'b1, {3{~pz}});
            check("pair3 carried bits", 32'h3f, {25'h0, link_a.pair3});
        end
        for (k = 0; k < 2; k++) begin
            pz = (k == 1) ? 8'h03 : 8'hc0;
            wr(bridge_pkg::OFF_LINK_CFG, 8'h0a | 8'(k));
            px(1'b0, 24'h0);
            px(1'b1, {3{8'hfc}});
            px(1'b1, {3{pz}});
            check("odd pixel on a", 32'h3f80, {18'h0, link_a.pair0, link_a.pair3});
            check("even pixel on b", 32'h3f, {25'h0, link_b.pair3});
        end
        check("link_b running", 32'h1, {31'h0, b_edges != b_mark});
        rd(bridge_pkg::OFF_IRQ_STATUS, 8'h0c);
        wr(bridge_pkg::OFF_IRQ_ENABLE, 8'h00);
        wr(bridge_pkg::OFF_IRQ_CLEAR, 8'h0f);
        for (k = 0; k < 2; k++) begin
            v = 8'($urandom_range(255, 1));
            @(posedge mclk);
            err_first_set <= (k == 0) ? v : 8'h00;
            err_second_set <= (k == 1) ? v : 8'h00;
            @(posedge mclk);
            err_first_set <= 8'h00;
            err_second_set <= 8'h00;
            rd(bridge_pkg::OFF_ERR_FIRST + 8'(k), v);
            rd(bridge_pkg::OFF_IRQ_STATUS, 8'(1 << k));
            check("irq masked", 32'h0, {31'h0, irq});
            wr(bridge_pkg::OFF_IRQ_ENABLE, 8'(1 << k));
            @(negedge mclk);
            check("irq raised", 32'h1, {31'h0, irq});
            bus(1'b0, bridge_pkg::OFF_ERR_FIRST + 8'(k), 8'hff, 4'he);
            rd(bridge_pkg::OFF_ERR_FIRST + 8'(k), v);
            wr(bridge_pkg::OFF_ERR_FIRST + 8'(k), 8'hff);
            rd(bridge_pkg::OFF_ERR_FIRST + 8'(k), bridge_pkg::ERR_CLEARED);
            wr(bridge_pkg::OFF_IRQ_CLEAR, 8'(1 << k));
            @(negedge mclk);
            check("irq cleared", 32'h0, {31'h0, irq});
        end
        stop_test();
    end
endmodule
